/* File: smc_params.svh */
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_SEL_IDLE 3'h0
`define SMC_SEL_ADCNR 3'h1
`define SMC_SEL_PDOWN 3'h2
`define SMC_SEL_PSAVE 3'h3
`define SMC_SEL_RSVD_A 3'h4
`define SMC_SEL_RSVD_B 3'h5
`define SMC_SEL_STBY 3'h6
`define SMC_SEL_XSTBY 3'h7
`define SMC_CLK_MHZ 250
`define SMC_HALT_CYC 4'h4
`define SMC_STBY_CYC 4'h6
`define SMC_UNLOCK_CYC 3'h4
`define SMC_BOD_WAKE_NS 60000
`define SMC_BOD_OFF_BIT 6
`define SMC_BOD_UNL_BIT 5
`define SMC_STARTUP_DFLT 16384
`endif

/* File: smc_pkg.sv */
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_ACTIVE = 3'h0,
        SMC_SLEEP = 3'h1,
        SMC_START = 3'h2,
        SMC_HALT = 3'h3,
        SMC_BODW = 3'h4
    } smc_state_e;
    typedef struct packed {
        logic core_clk_en;
        logic flash_clk_en;
        logic io_clk_en;
        logic conv_clk_en;
        logic async_clk_en;
        logic main_osc_en;
        logic timer_osc_en;
    } smc_clk_s;
    typedef struct packed {
        logic any_irq;
        logic ext_level;
        logic ext_edge;
        logic pin_change;
        logic twi_match;
        logic timer2_irq;
        logic spm_ready;
        logic conv_done;
        logic wdt_irq;
    } smc_wake_s;
endpackage

/* File: smc_ctrl.sv */
// Operation
// - Sleep entered only if arm bit set when sleep instruction executes.
// - Code 000 Idle: stop core and flash clocks, others run; timer oscillator follows timer 2 async choice.
// - Code 001 noise reduction: stop io, core, flash clocks.
// - Code 010 Power-down: all generated clocks and main oscillator stop.
// - Code 011 Power-save: as Power-down, enabled timer 2 wakes device.
// - Power-save oscillators follow timer 2 clocking choice.
// - Code 110 with crystal: Standby, oscillator runs, six-cycle wake.
// - Code 111 with crystal: Extended Standby, six-cycle wake.
// - Enabled interrupt wakes; core held four extra cycles after start-up.
// - Register file and static memory contents preserved across sleep.
// - Reset during sleep wakes and restarts at reset vector.
// - Enabled converter starts conversion entering Idle or noise reduction.
// - Idle wakes on every enabled interrupt.
// - Noise reduction ends only on its listed sources.
// - Power-down ends only on its listed sources.
// - Outside Idle, external pins wake only through level or pin-change interrupts.
// - Level interrupt gone before deep-mode start-up end: wake without interrupt.
// - Power-down wake delayed by fuse-selected start-up time.
// - Brown-out sleep-off turns detector off in deep modes, on at wake.
// - Detector off during sleep extends wake time to about 60 us.
// - Brown-out sleep-off at control bit 6, default zero, timed write.
// - Set by unlock write of both ones, then within four cycles.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_ctrl
    import smc_pkg::*;
#(
    parameter int STARTUP_CYC = `SMC_STARTUP_DFLT,
    parameter int BOD_WAKE_CYC = (`SMC_BOD_WAKE_NS * `SMC_CLK_MHZ + 999) / 1000
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Core interface.
    input wire logic sleep_instr,
    input wire logic sleep_arm_bit,
    input wire logic [2:0] sleep_select,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic ext_crystal,
    input wire logic reset_req,
    output logic core_halt,
    output logic irq_take,
    output logic restart_vector,
    output logic brownout_sleep_off,
    // Peripheral configuration and wake sources.
    input wire logic conv_enabled,
    input wire logic t2_async,
    input wire logic t2_sync,
    input wire logic t2_enabled,
    input wire smc_wake_s wake_in,
    output logic conv_start,
    output logic brownout_en,
    output smc_clk_s clk_en,
    output logic [2:0] state_out
);
    smc_state_e state_ff, nxt_state;
    logic [2:0] mode_ff;
    logic [15:0] cnt_ff;
    logic bod_off_ff, irq_pend_ff, rst_seen_ff;
    logic [2:0] unl_ff;
    logic wake, deep, go;

    // Deep modes allow brown-out switch-off and, except the standby codes, long start-up.
    function automatic logic is_deep(input logic [2:0] m);
        is_deep = (m == `SMC_SEL_PDOWN) || (m == `SMC_SEL_PSAVE) ||
                  (m == `SMC_SEL_STBY) || (m == `SMC_SEL_XSTBY);
    endfunction

    // Legal entry: arm bit, non-reserved code, crystal for standby codes.
    always_comb begin
        go = sleep_instr && sleep_arm_bit;
        if (sleep_select == `SMC_SEL_RSVD_A || sleep_select == `SMC_SEL_RSVD_B) begin
            go = 1'b0;
        end
        if ((sleep_select == `SMC_SEL_STBY || sleep_select == `SMC_SEL_XSTBY) && !ext_crystal) begin
            go = 1'b0;
        end
    end
    assign deep = is_deep(mode_ff);

    // Wake qualification per mode; edge pins count only in Idle.
    always_comb begin
        case (mode_ff)
            `SMC_SEL_IDLE: wake = wake_in.any_irq;
            `SMC_SEL_ADCNR: wake = wake_in.conv_done || wake_in.wdt_irq ||
                wake_in.twi_match || wake_in.timer2_irq || wake_in.spm_ready ||
                wake_in.ext_level || wake_in.pin_change;
            `SMC_SEL_PSAVE, `SMC_SEL_XSTBY: wake = wake_in.wdt_irq ||
                wake_in.twi_match || wake_in.ext_level || wake_in.pin_change ||
                (wake_in.timer2_irq && t2_enabled);
            default: wake = wake_in.wdt_irq || wake_in.twi_match ||
                wake_in.ext_level || wake_in.pin_change;
        endcase
    end

    // Sequencer state transitions.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SMC_ACTIVE: if (go) nxt_state = SMC_SLEEP;
            SMC_SLEEP: if (reset_req || wake) nxt_state = SMC_START;
            SMC_START: if (cnt_ff == 16'h0000) nxt_state = bod_off_ff ? SMC_BODW : SMC_HALT;
            SMC_BODW: if (cnt_ff == 16'h0000) nxt_state = SMC_HALT;
            SMC_HALT: if (cnt_ff == 16'h0000) nxt_state = SMC_ACTIVE;
            default: nxt_state = SMC_ACTIVE;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SMC_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Mode latch at entry.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= `SMC_SEL_IDLE;
        end else if (state_ff == SMC_ACTIVE && go) begin
            mode_ff <= sleep_select;
        end
    end

    // Delay counter loads on each phase entry, counts down to zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 16'h0000;
        end else if (state_ff == SMC_SLEEP && nxt_state == SMC_START) begin
            if (mode_ff == `SMC_SEL_STBY || mode_ff == `SMC_SEL_XSTBY) begin
                cnt_ff <= 16'(`SMC_STBY_CYC - 4'h1);
            end else if (deep) begin
                cnt_ff <= 16'(STARTUP_CYC - 1);
            end else begin
                cnt_ff <= 16'h0000;
            end
        end else if (state_ff == SMC_START && nxt_state == SMC_BODW) begin
            cnt_ff <= 16'(BOD_WAKE_CYC - 1);
        end else if (nxt_state == SMC_HALT && state_ff != SMC_HALT) begin
            cnt_ff <= 16'(`SMC_HALT_CYC - 4'h1);
        end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    // Timed unlock window and the sleep-off control bit.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unl_ff <= 3'h0;
            brownout_sleep_off <= 1'b0;
        end else begin
            if (ctrl_wr && ctrl_wdata[`SMC_BOD_OFF_BIT] && ctrl_wdata[`SMC_BOD_UNL_BIT]) begin
                unl_ff <= `SMC_UNLOCK_CYC;
            end else if (unl_ff != 3'h0) begin
                unl_ff <= unl_ff - 3'h1;
            end
            if (ctrl_wr && !ctrl_wdata[`SMC_BOD_UNL_BIT]) begin
                if (!ctrl_wdata[`SMC_BOD_OFF_BIT]) begin
                    brownout_sleep_off <= 1'b0;
                end else if (unl_ff != 3'h0) begin
                    brownout_sleep_off <= 1'b1;
                end
            end
        end
    end

    // Detector off only during sleep proper in deep modes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bod_off_ff <= 1'b0;
        end else if (state_ff == SMC_ACTIVE && go) begin
            bod_off_ff <= brownout_sleep_off && is_deep(sleep_select);
        end else if (state_ff == SMC_ACTIVE) begin
            bod_off_ff <= 1'b0;
        end
    end
    assign brownout_en = !(bod_off_ff && state_ff == SMC_SLEEP);

    // Interrupt level tracked through deep-mode start-up; a vanished level there yields none.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_pend_ff <= 1'b0;
            rst_seen_ff <= 1'b0;
        end else if (state_ff == SMC_SLEEP && nxt_state == SMC_START) begin
            irq_pend_ff <= !reset_req;
            rst_seen_ff <= reset_req;
        end else if (state_ff == SMC_START || state_ff == SMC_BODW) begin
            if (reset_req) rst_seen_ff <= 1'b1;
            irq_pend_ff <= !reset_req && (wake || (irq_pend_ff && !deep));
        end else if (state_ff == SMC_ACTIVE) begin
            irq_pend_ff <= 1'b0;
            rst_seen_ff <= 1'b0;
        end
    end

    // Core handshake outputs; state kept static so memories hold.
    assign core_halt = (state_ff != SMC_ACTIVE);
    assign irq_take = (state_ff == SMC_HALT) && (nxt_state == SMC_ACTIVE) &&
                      irq_pend_ff && !rst_seen_ff;
    assign restart_vector = (state_ff == SMC_HALT) && (nxt_state == SMC_ACTIVE) &&
                            rst_seen_ff;
    assign conv_start = (state_ff == SMC_ACTIVE) && go && conv_enabled &&
        (sleep_select == `SMC_SEL_IDLE || sleep_select == `SMC_SEL_ADCNR);
    assign state_out = state_ff;

    // Clock gating per mode while asleep.
    always_comb begin
        clk_en = '1;
        if (state_ff == SMC_SLEEP) begin
            clk_en.core_clk_en = 1'b0;
            clk_en.flash_clk_en = 1'b0;
            case (mode_ff)
                `SMC_SEL_IDLE: clk_en.timer_osc_en = t2_async;
                `SMC_SEL_ADCNR: begin
                    clk_en.io_clk_en = 1'b0;
                    clk_en.timer_osc_en = t2_async;
                end
                `SMC_SEL_PSAVE, `SMC_SEL_XSTBY: begin
                    clk_en.io_clk_en = 1'b0;
                    clk_en.conv_clk_en = 1'b0;
                    clk_en.async_clk_en = t2_async && t2_enabled;
                    clk_en.timer_osc_en = t2_async;
                    clk_en.main_osc_en = (mode_ff == `SMC_SEL_XSTBY) || (t2_sync && t2_enabled);
                end
                default: begin
                    clk_en.io_clk_en = 1'b0;
                    clk_en.conv_clk_en = 1'b0;
                    clk_en.async_clk_en = 1'b0;
                    clk_en.timer_osc_en = 1'b0;
                    clk_en.main_osc_en = (mode_ff == `SMC_SEL_STBY);
                end
            endcase
        end
    end

    // Checks.
    AST_ARM: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_ACTIVE && !sleep_arm_bit) |=> state_ff == SMC_ACTIVE)
        else $error("sleep entered without arm bit");
    AST_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_ACTIVE && sleep_select[2:1] == 2'b10) |=> state_ff == SMC_ACTIVE)
        else $error("reserved code entered sleep");
    AST_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_IDLE) |->
        (!clk_en.core_clk_en && clk_en.io_clk_en && clk_en.conv_clk_en))
        else $error("idle clocks wrong");
    AST_PDOWN: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_PDOWN) |->
        (!clk_en.main_osc_en && !clk_en.io_clk_en && !clk_en.conv_clk_en))
        else $error("power-down clocks wrong");
    AST_HALT4: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff != SMC_HALT ##1 state_ff == SMC_HALT) |->
        (state_ff == SMC_HALT)[*4] ##1 state_ff == SMC_ACTIVE)
        else $error("halt not four cycles");
    AST_STBY: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_STBY && wake && !bod_off_ff) |->
        ##7 state_ff == SMC_HALT)
        else $error("standby wake not six cycles");
    AST_BOD: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_ACTIVE && nxt_state == SMC_ACTIVE) |-> brownout_en)
        else $error("detector off while awake");
    AST_UNL: assert property (@(posedge clk) disable iff (!arst_n)
        (!brownout_sleep_off && unl_ff == 3'h0 &&
         !(ctrl_wr && ctrl_wdata[`SMC_BOD_UNL_BIT])) |=>
        !brownout_sleep_off)
        else $error("sleep-off set without unlock");
    AST_CONV: assert property (@(posedge clk) disable iff (!arst_n)
        conv_start |=> (state_ff == SMC_SLEEP && mode_ff[2:1] == 2'b00))
        else $error("conversion start outside idle or noise mode");

    // Noise reduction stops the io clock but keeps the converter clock.
    AST_NOISE: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_ADCNR) |->
        (!clk_en.core_clk_en && !clk_en.io_clk_en && clk_en.conv_clk_en))
        else $error("noise reduction clocks wrong");

    // Power-save oscillators follow how timer 2 is clocked.
    AST_PSAVE: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_PSAVE) |->
        (clk_en.timer_osc_en == t2_async && clk_en.main_osc_en == (t2_sync && t2_enabled)))
        else $error("power-save oscillators wrong");

    // Standby keeps only the main oscillator running.
    AST_STBYCLK: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_STBY) |->
        (clk_en.main_osc_en && !clk_en.io_clk_en && !clk_en.timer_osc_en))
        else $error("standby clocks wrong");

    // Extended standby keeps the main oscillator running.
    AST_XSTBY: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_XSTBY) |->
        (clk_en.main_osc_en && !clk_en.io_clk_en))
        else $error("extended standby clocks wrong");

    // A reset always ends sleep at the next edge.
    AST_WAKE_RST: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && reset_req) |=> state_ff == SMC_START)
        else $error("reset did not wake");

    // An edge request alone must not end a sleep other than Idle.
    AST_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff != `SMC_SEL_IDLE && !reset_req &&
         wake_in.ext_edge && !wake_in.ext_level && !wake_in.pin_change &&
         !wake_in.twi_match && !wake_in.wdt_irq && !wake_in.timer2_irq &&
         !wake_in.conv_done && !wake_in.spm_ready) |=> state_ff == SMC_SLEEP)
        else $error("edge request woke deep sleep");

    // Power-down ignores sources outside its own list.
    AST_PDSRC: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_PDOWN && !reset_req &&
         !wake_in.wdt_irq && !wake_in.twi_match && !wake_in.ext_level &&
         !wake_in.pin_change) |=> state_ff == SMC_SLEEP)
        else $error("power-down woke on foreign source");

    // Idle wakes on any enabled interrupt.
    AST_IDLEWAKE: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_IDLE && wake_in.any_irq) |=>
        state_ff == SMC_START)
        else $error("idle did not wake on interrupt");

    // An enabled timer 2 event ends Power-save.
    AST_TIMER: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_PSAVE && wake_in.timer2_irq &&
         t2_enabled) |=> state_ff == SMC_START)
        else $error("timer 2 did not wake power-save");

    // A reset wake never runs the interrupt handler.
    AST_VEC: assert property (@(posedge clk) disable iff (!arst_n)
        restart_vector |-> !irq_take)
        else $error("interrupt taken on reset wake");

    // The handler starts as the core resumes.
    AST_IRQ_END: assert property (@(posedge clk) disable iff (!arst_n)
        irq_take |=> state_ff == SMC_ACTIVE)
        else $error("interrupt taken before resume");

    // Start-up may skip the extended wait only with the detector kept on.
    AST_BODW: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_START && nxt_state == SMC_HALT) |-> !bod_off_ff)
        else $error("extended wait skipped");

    // Entering Power-down with sleep-off set turns the detector off.
    AST_BODON: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == SMC_ACTIVE && go && brownout_sleep_off &&
         sleep_select == `SMC_SEL_PDOWN) |=> !brownout_en)
        else $error("detector left on in power-down");

    COV_IDLE: cover property (@(posedge clk) disable iff (!arst_n)
        state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_IDLE ##[1:20] irq_take);
    COV_RST: cover property (@(posedge clk) disable iff (!arst_n) restart_vector);
    COV_BODW: cover property (@(posedge clk) disable iff (!arst_n) state_ff == SMC_BODW);

    // Standby wake and a wake whose level vanished.
    COV_STBY: cover property (@(posedge clk) disable iff (!arst_n)
        state_ff == SMC_SLEEP && mode_ff == `SMC_SEL_STBY ##1 state_ff == SMC_START);
    COV_SHORT: cover property (@(posedge clk) disable iff (!arst_n)
        state_ff == SMC_HALT && nxt_state == SMC_ACTIVE && !irq_pend_ff && !rst_seen_ff);
endmodule
`default_nettype wire

/* File: smc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_partner
    import smc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Requests from the bench.
    input wire smc_wake_s src_req,
    input wire logic src_short,
    // Acknowledge from the core side.
    input wire logic irq_take,
    input wire logic restart_vector,
    // Wake levels toward the controller.
    output var smc_wake_s wake_in
);
    // A wake level stands until the core takes it, unless a short glitch is asked for.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_in <= '0;
        end else if (src_req != '0) begin
            wake_in <= src_req;
        end else if (src_short || irq_take || restart_vector) begin
            wake_in <= '0;
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb
    import smc_pkg::*;
;
    // Stimulus, observation and tallies.
    logic clk = 0, arst_n = 0, sleep_instr = 0, sleep_arm_bit = 0, ctrl_wr = 0;
    logic ext_crystal = 1, reset_req = 0, src_short = 0, conv_enabled = 1;
    logic [2:0] sleep_select = 3'h0;
    logic [7:0] ctrl_wdata = 8'h00;
    smc_wake_s src_req = '0;
    smc_wake_s wake_in;
    smc_clk_s clk_en;
    logic core_halt, irq_take, restart_vector, brownout_sleep_off, conv_start, brownout_en;
    logic [2:0] state_out;
    int err_total = 0, check_count = 0;
    int n_start, n_halt, n_bodw, n_irq, n_rst, n_conv;
    logic [2:0] m_sel [6] = '{`SMC_SEL_IDLE, `SMC_SEL_ADCNR, `SMC_SEL_PDOWN,
        `SMC_SEL_PSAVE, `SMC_SEL_STBY, `SMC_SEL_XSTBY};
    logic [6:0] m_clk [6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [8:0] m_wake [6] = '{9'h100, 9'h002, 9'h001, 9'h008, 9'h080, 9'h020};
    logic [8:0] m_probe [6] = '{9'h000, 9'h040, 9'h042, 9'h042, 9'h042, 9'h042};
    int m_start [6] = '{1, 1, 8, 8, 6, 6};
    int m_conv [6] = '{1, 0, 0, 0, 0, 0};

    smc_ctrl #(.STARTUP_CYC(8), .BOD_WAKE_CYC(10)) i_dut (.clk(clk), .arst_n(arst_n),
        .sleep_instr(sleep_instr), .sleep_arm_bit(sleep_arm_bit),
        .sleep_select(sleep_select), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .ext_crystal(ext_crystal), .reset_req(reset_req), .core_halt(core_halt),
        .irq_take(irq_take), .restart_vector(restart_vector),
        .brownout_sleep_off(brownout_sleep_off), .conv_enabled(conv_enabled), .t2_async(1'b1),
        .t2_sync(1'b0), .t2_enabled(1'b1), .wake_in(wake_in), .conv_start(conv_start),
        .brownout_en(brownout_en), .clk_en(clk_en), .state_out(state_out));
    smc_partner i_partner (.clk(clk), .arst_n(arst_n), .src_req(src_req),
        .src_short(src_short), .irq_take(irq_take), .restart_vector(restart_vector),
        .wake_in(wake_in));

    // Clock of 4 ns period.
    always #2 clk = ~clk;

    // Tally wake-up phases and one-cycle pulses as the edge samples them.
    always @(posedge clk) begin
        n_start += (state_out === SMC_START);
        n_halt += (state_out === SMC_HALT);
        n_bodw += (state_out === SMC_BODW);
        n_irq += (irq_take === 1'b1);
        n_rst += (restart_vector === 1'b1);
        n_conv += (conv_start === 1'b1);
    end

    // Issue one sleep instruction, then look just after the following edge.
    task automatic enter(input logic [2:0] sel, input logic arm, input logic xtal);
        {n_start, n_halt, n_bodw, n_irq, n_rst, n_conv} = '0;
        @(posedge clk);
        sleep_select <= sel;
        sleep_arm_bit <= arm;
        ext_crystal <= xtal;
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
        sleep_arm_bit <= 1'b0;
        #1;
    endtask

    // Raise a wake level or a reset and wait, bounded, for the core to run.
    task automatic wake(input smc_wake_s w, input logic rst);
        int k;
        k = 0;
        @(posedge clk);
        src_req <= w;
        reset_req <= rst;
        @(posedge clk);
        src_req <= '0;
        while (k < 200 && core_halt !== 1'b0) begin
            @(posedge clk);
            #1;
            k++;
        end
        reset_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // One write of the core control register.
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= d;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        #1;
    endtask

    // Unarmed, reserved and crystal-less requests leave the core running.
    task automatic t_refuse();
        enter(3'h0, 1'b0, 1'b1);
        `CHK("no_arm", 1'b0, core_halt)
        enter(3'h4, 1'b1, 1'b1);
        `CHK("code4", 1'b0, core_halt)
        enter(3'h5, 1'b1, 1'b1);
        `CHK("code5", 1'b0, core_halt)
        enter(3'h6, 1'b1, 1'b0);
        `CHK("no_xtal", 1'b0, core_halt)
    endtask

    // Each mode: clock gating, foreign sources ignored, start-up and halt lengths.
    task automatic t_mode(input int i);
        // The converter is switched off for noise reduction to see no start.
        @(posedge clk);
        conv_enabled <= (i != 1);
        enter(m_sel[i], 1'b1, 1'b1);
        `CHK("halt", 1'b1, core_halt)
        `CHK("clocks", m_clk[i], clk_en)
        @(posedge clk);
        src_req <= m_probe[i];
        repeat (10) @(posedge clk);
        #1;
        `CHK("probe", 1'b1, core_halt)
        wake(m_wake[i], 1'b0);
        `CHK("start", m_start[i], n_start)
        `CHK("halt4", 4, n_halt)
        `CHK("irq", 1, n_irq)
        `CHK("conv", m_conv[i], n_conv)
    endtask

    // Timed unlock, detector off in deep sleep, extended wake.
    task automatic t_bod();
        wr(8'h40);
        `CHK("off_bare", 1'b0, brownout_sleep_off)
        wr(8'h60);
        repeat (5) @(posedge clk);
        wr(8'h40);
        `CHK("off_late", 1'b0, brownout_sleep_off)
        wr(8'h60);
        wr(8'h40);
        #1;
        `CHK("off_set", 1'b1, brownout_sleep_off)
        enter(`SMC_SEL_PDOWN, 1'b1, 1'b1);
        `CHK("bod_sleep", 1'b0, brownout_en)
        wake(9'h001, 1'b0);
        `CHK("bod_wake", 10, n_bodw)
        `CHK("bod_back", 1'b1, brownout_en)
        wr(8'h00);
    endtask

    // Reset wake goes to the vector; a vanished level wakes without interrupt.
    task automatic t_reset_short();
        enter(`SMC_SEL_PDOWN, 1'b1, 1'b1);
        wake('0, 1'b1);
        `CHK("rst_vec", 1, n_rst)
        `CHK("rst_irq", 0, n_irq)
        src_short <= 1'b1;
        enter(`SMC_SEL_PDOWN, 1'b1, 1'b1);
        wake(9'h080, 1'b0);
        `CHK("short_up", 1'b0, core_halt)
        `CHK("short_irq", 0, n_irq)
        src_short <= 1'b0;
    endtask

    // Print the counts and the verdict, then stop.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence after 20 cycles of reset.
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        `CHK("rst_off", 1'b0, brownout_sleep_off)
        `CHK("rst_bod", 1'b1, brownout_en)
        `CHK("rst_clk", 7'h7f, clk_en)
        t_refuse();
        for (int i = 0; i < 6; i++) begin
            t_mode(i);
        end
        t_bod();
        t_reset_short();
        finish_test();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #200us;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
